// *** srd_regs.vh ***
/*
  constants for the serial relay driver chain: chain length, relay bit
  positions inside the latched word, and power-on guard timing.
  assumes: included by srd_*.v files; 125 MHz ref_clk.
*/
`ifndef SRD_REGS_VH
`define SRD_REGS_VH

// update length in bytes and bits
`define SRD_UPDATE_BYTES      3
`define SRD_UPDATE_BITS       24
`define SRD_STAGE_BITS        8
// bit positions in the latched word (word bit 0 = last bit shifted in)
`define SRD_CH_FIRST_POS      0
`define SRD_CH_COUNT          10
`define SRD_CH5_POS           4
`define SRD_CH10_POS          9
`define SRD_POLE_CFG_POS      10
`define SRD_SSW_ENA_POS       11
// latched word after reset: all drivers high, relays at rest
`define SRD_LATCH_RESET       24'hFFFFFF
// power-on guard settle time, and the clock rate it is counted at
`define SRD_GUARD_US          10
`define SRD_CLK_MHZ           125
`define SRD_GUARD_CYCLES      (`SRD_GUARD_US * `SRD_CLK_MHZ)

`endif

// *** srd_stage.v ***
/*
  one relay driver stage: 8-bit shift register, cascade serial output,
  and output latch loaded on strobe.
  assumes: shiftEn and strobeEn are single-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
`include "srd_regs.vh"

module srd_stage #(
  parameter WIDTH = `SRD_STAGE_BITS
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire             clkEn,
  input  wire             shiftEn,
  input  wire             strobeEn,
  input  wire             serIn,
  output wire             serOut,
  output wire [WIDTH-1:0] latchOut
);

  reg [WIDTH-1:0] shift_q;
  reg [WIDTH-1:0] latch_q;

  // shift in at bit 0; the top bit overflows to the next stage
  always @(posedge ref_clk) begin
    if (rst) begin
      shift_q <= {WIDTH{1'b1}};
      latch_q <= {WIDTH{1'b1}};
    end else if (clkEn) begin
      if (shiftEn) begin
        shift_q <= {shift_q[WIDTH-2:0], serIn};
      end
      if (strobeEn) begin
        latch_q <= shift_q;
      end
    end
  end

  assign serOut   = shift_q[WIDTH-1];
  assign latchOut = latch_q;

endmodule

// *** srd_relay_chain.v ***
/*
  serial relay driver chain of the scanner card: three cascaded stages,
  active-low relay driver outputs, solid-state switch selection for
  channels 5 and 10, and a power-on guard on the driver output enable.
  assumes: serial clock, data and strobe come from the host as pins and
  are sampled here on ref_clk (125 MHz); serial clock is much slower.
*/
`timescale 1ns/1ps
`include "srd_regs.vh"

module srd_relay_chain #(
  parameter STAGES       = `SRD_UPDATE_BYTES,
  parameter GUARD_CYCLES = `SRD_GUARD_CYCLES
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire        serData,
  input  wire        serClk,
  input  wire        strobe,
  input  wire        powerGood,
  input  wire        internalScan,
  input  wire        scanOnly5And10,
  input  wire        sameFunction,
  output reg  [9:0]  chRelay_n,
  output reg         poleConfigRelay_n,
  output reg         ch5LatchingRelay_n,
  output reg         ch10LatchingRelay_n,
  output reg         solidStateSwitchA,
  output reg         solidStateSwitchB,
  output wire        outEnable_n,
  output wire        chainSerOut,
  output reg  [4:0]  bitCount
);

  localparam NBITS = STAGES * `SRD_STAGE_BITS;

  // two-flop synchronisers for the pin inputs
  reg [1:0] dataSync_q;
  reg [1:0] clkSync_q;
  reg [1:0] strobeSync_q;
  reg [1:0] pgSync_q;
  reg       clkPrev_q;
  reg       strobePrev_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      dataSync_q   <= 2'h0;
      clkSync_q    <= 2'h0;
      strobeSync_q <= 2'h0;
      pgSync_q     <= 2'h0;
      clkPrev_q    <= 1'b0;
      strobePrev_q <= 1'b0;
    end else if (clkEn) begin
      dataSync_q   <= {dataSync_q[0], serData};
      clkSync_q    <= {clkSync_q[0], serClk};
      strobeSync_q <= {strobeSync_q[0], strobe};
      pgSync_q     <= {pgSync_q[0], powerGood};
      clkPrev_q    <= clkSync_q[1];
      strobePrev_q <= strobeSync_q[1];
    end
  end

  // data is sampled with the clock edge; host keeps data stable around it
  wire shiftPulse  = clkSync_q[1] & ~clkPrev_q;
  wire strobePulse = strobeSync_q[1] & ~strobePrev_q;

  // cascade of stages; overflow of one feeds the next
  wire [STAGES:0]   chainLink;
  wire [NBITS-1:0]  latched;
  assign chainLink[0] = dataSync_q[1];

  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi = gi + 1) begin : gStage
      srd_stage #(
        .WIDTH (`SRD_STAGE_BITS)
      ) uStage (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .shiftEn  (shiftPulse),
        .strobeEn (strobePulse),
        .serIn    (chainLink[gi]),
        .serOut   (chainLink[gi+1]),
        .latchOut (latched[gi*`SRD_STAGE_BITS +: `SRD_STAGE_BITS])
      );
    end
  endgenerate

  assign chainSerOut = chainLink[STAGES];

  // bits received since the last strobe, saturating; shows a full update
  always @(posedge ref_clk) begin
    if (rst) begin
      bitCount <= 5'h00;
    end else if (clkEn) begin
      if (strobePulse) begin
        bitCount <= 5'h00;
      end else if (shiftPulse && bitCount != 5'h1F) begin
        bitCount <= bitCount + 5'h01;
      end
    end
  end

  // power-on guard: enable only after power has been good for a settle time
  reg [31:0] guardCnt_q;
  reg        guardOk_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      guardCnt_q <= 32'h00000000;
      guardOk_q  <= 1'b0;
    end else if (clkEn) begin
      if (!pgSync_q[1]) begin
        guardCnt_q <= 32'h00000000;
        guardOk_q  <= 1'b0;
      end else if (guardCnt_q >= GUARD_CYCLES - 1) begin
        guardOk_q  <= 1'b1;
      end else begin
        guardCnt_q <= guardCnt_q + 32'h00000001;
      end
    end
  end

  assign outEnable_n = ~guardOk_q;

  // solid-state path needs all three scan conditions and the latched request
  wire sswUse = internalScan & scanOnly5And10 & sameFunction
                & ~latched[`SRD_SSW_ENA_POS];

  // register the drivers; disabled relay drivers rest high and switches low so nothing moves
  always @(posedge ref_clk) begin
    if (rst) begin
      chRelay_n           <= 10'h3FF;
      poleConfigRelay_n   <= 1'b1;
      ch5LatchingRelay_n  <= 1'b1;
      ch10LatchingRelay_n <= 1'b1;
      solidStateSwitchA   <= 1'b0;
      solidStateSwitchB   <= 1'b0;
    end else if (clkEn) begin
      if (!guardOk_q) begin
        chRelay_n           <= 10'h3FF;
        poleConfigRelay_n   <= 1'b1;
        ch5LatchingRelay_n  <= 1'b1;
        ch10LatchingRelay_n <= 1'b1;
        solidStateSwitchA   <= 1'b0;
        solidStateSwitchB   <= 1'b0;
      end else begin
        // channel selection from the ten channel bits only
        chRelay_n <= latched[`SRD_CH_FIRST_POS +: `SRD_CH_COUNT];
        poleConfigRelay_n <= latched[`SRD_POLE_CFG_POS];
        if (sswUse) begin
          ch5LatchingRelay_n  <= 1'b1;
          ch10LatchingRelay_n <= 1'b1;
          solidStateSwitchA   <= ~latched[`SRD_CH5_POS];
          solidStateSwitchB   <= ~latched[`SRD_CH10_POS];
        end else begin
          ch5LatchingRelay_n  <= latched[`SRD_CH5_POS];
          ch10LatchingRelay_n <= latched[`SRD_CH10_POS];
          solidStateSwitchA   <= 1'b0;
          solidStateSwitchB   <= 1'b0;
        end
      end
    end
  end

endmodule

// *** srd_host_model.sv ***
/*
  host side of the relay link: shifts 24 bits msb first, then strobes.
  assumes: ref_clk only paces the pins; serial clock idles low.
*/
`timescale 1ns/1ps
module srd_host_model (
  input  wire ref_clk,
  output reg  serData,
  output reg  serClk,
  output reg  strobe
);
  initial begin
    serData = 1'b0;
    serClk = 1'b0;
    strobe = 1'b0;
  end
  // pins move 1 ns after an edge
  task automatic tick(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // 64 ns serial clock, data held 4 cycles either side of the rise
  task automatic send(input [23:0] w, input doStb);
    integer i;
    for (i = 23; i >= 0; i--) begin
      serData = w[i];
      tick(4);
      serClk = 1'b1;
      tick(4);
      serClk = 1'b0;
    end
    serData = ~w[0]; // data driven to the inverse of the last bit, stale value not kept
    if (doStb) begin
      tick(4);
      strobe = 1'b1;
      tick(6);
      strobe = 1'b0;
    end
    tick(4);
  endtask
endmodule

// *** srd_chain_checker.sv ***
/*
  assertions on srd_relay_chain pins.
  assumes: GUARD_CYCLES of 8 or more; pin timing as in the hand-over.
*/
`timescale 1ns/1ps
module srd_chain_checker (
  input wire       ref_clk,
  input wire       rst,
  input wire       clkEn,
  input wire       serClk,
  input wire       strobe,
  input wire       powerGood,
  input wire [9:0] chRelay_n,
  input wire       poleConfigRelay_n,
  input wire       ch5LatchingRelay_n,
  input wire       ch10LatchingRelay_n,
  input wire       solidStateSwitchA,
  input wire       solidStateSwitchB,
  input wire       outEnable_n,
  input wire [4:0] bitCount
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !clkEn);
  // two sync flops and one edge or count register sit between pins and logic
  sequence s_strobe_rise; !strobe ##1 strobe; endsequence
  sequence s_pwr_lost; !powerGood [*3]; endsequence
  a_enable_off_drv: assert property (outEnable_n && $past(outEnable_n) |-> chRelay_n == 10'h3FF
    && poleConfigRelay_n && !solidStateSwitchA && !solidStateSwitchB)
    else $error("driver active while disabled");
  a_power_loss: assert property (s_pwr_lost |=> outEnable_n)
    else $error("enable kept after supply loss");
  a_guard_wait: assert property ($rose(powerGood) |=> outEnable_n [*8])
    else $error("enable released too early");
  a_chain_quiet: assert property ($changed(chRelay_n) || $changed(poleConfigRelay_n)
    |-> $past(bitCount) == 5'h00)
    else $error("drivers moved during shifting");
  a_count_step: assert property ($changed(bitCount) && bitCount != 5'h00
    |-> bitCount == $past(bitCount) + 5'h01)
    else $error("bit count skipped");
  a_strobe_latch: assert property (s_strobe_rise |-> ##3 bitCount == 5'h00)
    else $error("strobe did not latch");
  a_shift_count: assert property ($rose(serClk) |-> ##3 (bitCount == $past(bitCount, 3) + 5'h01
    || $past(bitCount, 3) == 5'h1F))
    else $error("serial clock edge not taken");
  a_ssw_relay_off: assert property (solidStateSwitchA || solidStateSwitchB
    |-> ch5LatchingRelay_n && ch10LatchingRelay_n)
    else $error("relay and switch both on");
endmodule
bind srd_relay_chain srd_chain_checker chk (.*);

// *** srd_relay_chain_tb_top.sv ***
/*
  self-checking bench for srd_relay_chain with the host model.
  assumes: clkEn tied high; guard shortened to 8 cycles.
*/
`timescale 1ns/1ps
module srd_relay_chain_tb_top;
  logic ref_clk, rst, powerGood, internalScan, scanOnly5And10, sameFunction;
  wire serData, serClk, strobe, pole, c5, c10, ssA, ssB, outEn_n, serOut;
  wire [9:0] ch_n;
  wire [4:0] bitCount;
  integer err_total, num_checks, i;
  logic [31:0] seed = 32'h8533;
  logic [23:0] w, lastW;
  always #4 ref_clk = ~ref_clk;
  srd_host_model host (.ref_clk(ref_clk), .serData(serData), .serClk(serClk), .strobe(strobe));
  srd_relay_chain #(.GUARD_CYCLES(8)) dut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1),
    .serData(serData), .serClk(serClk), .strobe(strobe), .powerGood(powerGood),
    .internalScan(internalScan), .scanOnly5And10(scanOnly5And10),
    .sameFunction(sameFunction), .chRelay_n(ch_n), .poleConfigRelay_n(pole),
    .ch5LatchingRelay_n(c5), .ch10LatchingRelay_n(c10), .solidStateSwitchA(ssA),
    .solidStateSwitchB(ssB), .outEnable_n(outEn_n), .chainSerOut(serOut), .bitCount(bitCount));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // switch path only with all scan conditions and bit 11 low
  function logic [3:0] exp4(input [23:0] v, input c);
    return (c && !v[11]) ? {2'b11, ~v[4], ~v[9]} : {v[4], v[9], 2'b00};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task upd(input [23:0] v, input c);
    {internalScan, scanOnly5And10, sameFunction} = {3{c}};
    host.send(v, 1'b1);
    lastW = v;
    chk({c5, c10, ssA, ssB}, exp4(v, c));
    if (!(c && !v[11])) chk({pole, ch_n}, v[10:0]);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, far beyond the ten frames sent
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
  initial begin
    {ref_clk, rst, powerGood, internalScan, scanOnly5And10, sameFunction} = 6'h38;
    err_total = 0;
    num_checks = 0;
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk({ch_n, pole, c5, c10, ssA, ssB, outEn_n, bitCount}, 21'h1FFF20);
    repeat (16) @(posedge ref_clk);
    #1 chk(outEn_n, 1'b0);
    // corners first, then random words, scan conditions on at the end
    for (i = 0; i < 8; i++) begin
      w = (i == 0) ? 24'h000000 : (i == 1) ? 24'hFFFFFF : rnd();
      if (i == 6) w[11] = 1'b0;
      upd(w, i > 5);
    end
    $display("word test done");
    w = rnd();
    host.send(w[23:0], 1'b0);
    chk(bitCount, 5'h18);
    chk(serOut, w[23]);
    chk({pole, ch_n}, lastW[10:0]);
    upd(rnd(), 1'b0);
    $display("overflow test done");
    powerGood = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk({outEn_n, pole, ch_n}, 12'hFFF);
    powerGood = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1 chk({outEn_n, pole, ch_n}, {1'b0, lastW[10:0]});
    $display("guard test done");
    end_of_test;
  end
endmodule
